// ### rtl/asrc_core.sv
module asrc_core
    import asrc_pkg::*;
#(
    parameter int SW = SMP_W,
    parameter int DEPTH = RAM_DEPTH
)
(
    input wire logic sys_clk_in,
    input wire logic reset_in,
    input wire logic in_strobe_in,
    input wire logic signed [SW-1:0] in_left_in,
    input wire logic signed [SW-1:0] in_right_in,
    input wire logic out_strobe_in,
    input wire logic cfg_wr_in,
    input wire logic [7:0] cfg_data_in,
    input wire logic settle_irq_en_in,
    output logic [7:0] cfg_data_out,
    output logic signed [SW-1:0] out_left_out,
    output logic signed [SW-1:0] out_right_out,
    output logic out_valid_out,
    output logic settle_warn_out,
    output logic settle_irq_out,
    output logic [7:0] rate_ratio_out
);
    localparam int AW = $clog2(DEPTH);
    localparam int PH_W = AW + FRAC_W;
    localparam int ROM_W = FRAC_W + TAP_LOG;

    // ----------------------------------------
    // Configuration register
    // ----------------------------------------
    logic [7:0] cfg_r;
    always_ff @(posedge sys_clk_in or posedge reset_in)
    begin
        if (reset_in)
            cfg_r <= CFG_RESET;
        else if (cfg_wr_in)
            cfg_r <= cfg_data_in;
    end
    assign cfg_data_out = cfg_r;

    // ----------------------------------------
    // Input stage
    // ----------------------------------------
    logic [AW-1:0] in_cnt_r;
    logic [AW-1:0] wr_addr;
    logic [7:0] gain_r;
    logic [7:0] ratio_r;
    logic [13:0] scale;
    logic signed [SW+14:0] lprod;
    logic signed [SW+14:0] rprod;
    logic signed [SW-1:0] ram_l [DEPTH];
    logic signed [SW-1:0] ram_r [DEPTH];
    logic [DEPTH-1:0] ram_ok_r;

    assign wr_addr = in_cnt_r + AW'(OFFSET_MIN) + AW'(cfg_r[DELAY_MSB:0]);
    assign scale = 14'(ratio_r) * 14'(gain_r);
    assign lprod = in_left_in * $signed({1'b0, scale});
    assign rprod = in_right_in * $signed({1'b0, scale});

    always_ff @(posedge sys_clk_in or posedge reset_in)
    begin
        if (reset_in)
            in_cnt_r <= '0;
        else if (in_strobe_in)
            in_cnt_r <= in_cnt_r + 1'b1;
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (in_strobe_in)
        begin
            ram_l[wr_addr] <= lprod[SW+11:12];
            ram_r[wr_addr] <= rprod[SW+11:12];
        end
    end

    // Words not yet written since reset read as silence
    always_ff @(posedge sys_clk_in or posedge reset_in)
    begin
        if (reset_in)
            ram_ok_r <= '0;
        else if (in_strobe_in)
            ram_ok_r[wr_addr] <= 1'b1;
    end

    always_ff @(posedge sys_clk_in or posedge reset_in)
    begin
        if (reset_in)
            gain_r <= GAIN_FULL;
        else if (in_strobe_in)
        begin
            if (cfg_r[MUTE_BIT] && gain_r != 8'h00)
                gain_r <= gain_r - 8'h01;
            else if (!cfg_r[MUTE_BIT] && gain_r < GAIN_FULL)
                gain_r <= gain_r + 8'h01;
        end
    end

    // ----------------------------------------
    // Rate ratio measurement
    // ----------------------------------------
    logic [TAP_LOG-1:0] win_cnt_r;
    logic [7:0] nout_r;
    logic [7:0] meas;
    logic [7:0] rdiff;

    assign meas = (nout_r >= RATIO_ONE) ? RATIO_ONE :
                  (nout_r < RATIO_MIN) ? RATIO_MIN : nout_r;
    assign rdiff = (meas > ratio_r) ? meas - ratio_r : ratio_r - meas;

    always_ff @(posedge sys_clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            win_cnt_r <= '0;
            nout_r <= 8'h00;
            ratio_r <= RATIO_ONE;
        end
        else
        begin
            if (in_strobe_in)
                win_cnt_r <= win_cnt_r + 1'b1;
            if (in_strobe_in && win_cnt_r == '1)
            begin
                nout_r <= {7'h00, out_strobe_in};
                if (rdiff > RATIO_HYST || meas == RATIO_ONE)
                    ratio_r <= meas;
            end
            else if (out_strobe_in && nout_r != 8'hff)
                nout_r <= nout_r + 8'h01;
        end
    end
    assign rate_ratio_out = ratio_r;

    // ----------------------------------------
    // Digital servo loop
    // ----------------------------------------
    logic [PH_W-1:0] phase_r;
    logic signed [PH_W-1:0] step_r;
    logic signed [PH_W-1:0] err;
    logic [PH_W-1:0] err_abs;
    logic fast_r;
    logic irq_r;
    logic [6:0] settle_cnt_r;

    assign err = $signed({in_cnt_r, FRAC_W'(0)} - phase_r);
    assign err_abs = err[PH_W-1] ? PH_W'(-err) : PH_W'(err);

    always_ff @(posedge sys_clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            phase_r <= '0;
            step_r <= PH_W'(1) <<< FRAC_W;
        end
        else if (out_strobe_in)
        begin
            if (fast_r)
            begin
                step_r <= step_r + (err >>> FAST_I_SH);
                phase_r <= phase_r + PH_W'(step_r + (err >>> FAST_P_SH));
            end
            else
            begin
                step_r <= step_r + (err >>> SLOW_I_SH);
                phase_r <= phase_r + PH_W'(step_r + (err >>> SLOW_P_SH));
            end
        end
    end

    always_ff @(posedge sys_clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            fast_r <= 1'b1;
            settle_cnt_r <= '0;
            irq_r <= 1'b0;
        end
        else
        begin
            irq_r <= 1'b0;
            if (out_strobe_in)
            begin
                if (fast_r)
                begin
                    if (err_abs >= (PH_W'(SETTLED_SMP) << FRAC_W))
                        settle_cnt_r <= '0;
                    else if (settle_cnt_r == SETTLE_CNT - 7'h01)
                    begin
                        fast_r <= 1'b0;
                        settle_cnt_r <= '0;
                        irq_r <= settle_irq_en_in;
                    end
                    else
                        settle_cnt_r <= settle_cnt_r + 7'h01;
                end
                else if (err_abs > (PH_W'(UNLOCK_SMP) << FRAC_W))
                    fast_r <= 1'b1;
            end
        end
    end
    assign settle_warn_out = fast_r;
    assign settle_irq_out = irq_r;

    // ----------------------------------------
    // Coefficient table with interpolation
    // ----------------------------------------
    function automatic logic signed [16:0] coef_f(input logic [6:0] i);
        int v;
        v = (int'(i) * (TAPS - int'(i)) * 3) >> 2;
        return 17'(v);
    endfunction : coef_f

    logic [ROM_W-1:0] rom_r;
    logic [TAP_LOG-1:0] cidx;
    logic [7:0] csub;
    logic signed [16:0] c0;
    logic signed [16:0] c1;
    logic signed [25:0] cdel;
    logic signed [16:0] coef;

    assign cidx = rom_r[ROM_W-1:FRAC_W];
    assign csub = rom_r[FRAC_W-1:FRAC_W-8];
    assign c0 = coef_f({1'b0, cidx});
    assign c1 = coef_f(7'({1'b0, cidx}) + 7'h01);
    assign cdel = 26'(c1 - c0) * $signed({18'h0, csub});
    assign coef = c0 + 17'(cdel >>> 8);

    // ----------------------------------------
    // Convolution engine
    // ----------------------------------------
    asrc_state_t state_r;
    logic [AW-1:0] rd_r;
    logic signed [ACC_W-1:0] acc_l_r;
    logic signed [ACC_W-1:0] acc_r_r;
    logic [27:0] frac_mul;
    logic [ROM_W-1:0] tap_step;
    logic [ROM_W:0] rom_sum;
    logic signed [SW-1:0] mac_a;
    logic signed [SW+16:0] mac_p;

    assign frac_mul = 28'(phase_r[FRAC_W-1:0]) * 28'(ratio_r);
    assign tap_step = ROM_W'({ratio_r, 14'h0000});
    assign rom_sum = {1'b0, rom_r} + {1'b0, tap_step};
    assign mac_a = !ram_ok_r[rd_r] ? '0 :
                   (state_r == ST_MACL) ? ram_l[rd_r] : ram_r[rd_r];
    assign mac_p = mac_a * coef;

    function automatic logic signed [SW-1:0] sat_f(input logic signed [ACC_W-1:0] a);
        logic signed [ACC_W-1:0] s;
        s = a >>> OUT_SH;
        if (s > $signed(ACC_W'({1'b0, {(SW-1){1'b1}}})))
            return {1'b0, {(SW-1){1'b1}}};
        else if (s < -$signed(ACC_W'({1'b0, {(SW-1){1'b1}}})))
            return {1'b1, {(SW-2){1'b0}}, 1'b1};
        return s[SW-1:0];
    endfunction : sat_f

    always_ff @(posedge sys_clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            state_r <= ST_IDLE;
            rd_r <= '0;
            rom_r <= '0;
            acc_l_r <= '0;
            acc_r_r <= '0;
            out_left_out <= '0;
            out_right_out <= '0;
            out_valid_out <= 1'b0;
        end
        else
        begin
            out_valid_out <= 1'b0;
            unique case (state_r)
                ST_IDLE:
                    if (out_strobe_in)
                        state_r <= ST_LOAD;
                ST_LOAD:
                begin
                    rd_r <= phase_r[PH_W-1:FRAC_W];
                    rom_r <= ROM_W'(frac_mul[FRAC_W+5:6]);
                    acc_l_r <= '0;
                    acc_r_r <= '0;
                    state_r <= ST_MACL;
                end
                ST_MACL:
                begin
                    acc_l_r <= acc_l_r + ACC_W'(mac_p);
                    state_r <= ST_MACR;
                end
                ST_MACR:
                begin
                    acc_r_r <= acc_r_r + ACC_W'(mac_p);
                    rd_r <= rd_r - 1'b1;
                    rom_r <= rom_sum[ROM_W-1:0];
                    state_r <= rom_sum[ROM_W] ? ST_DONE : ST_MACL;
                end
                ST_DONE:
                begin
                    out_left_out <= sat_f(acc_l_r);
                    out_right_out <= sat_f(acc_r_r);
                    out_valid_out <= 1'b1;
                    state_r <= ST_IDLE;
                end
                default:
                    state_r <= ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    property p_wr_offset;
        @(posedge sys_clk_in) disable iff (reset_in)
        cfg_wr_in |=> AW'(wr_addr - in_cnt_r) == AW'(OFFSET_MIN) + AW'($past(cfg_data_in[6:0]));
    endproperty
    a_wr_offset: assert property (p_wr_offset) else $error("write offset wrong");

    property p_mute_ramp;
        @(posedge sys_clk_in) disable iff (reset_in)
        (cfg_r[MUTE_BIT] && !cfg_wr_in && in_strobe_in && gain_r != 8'h00)
            |=> gain_r == $past(gain_r) - 8'h01;
    endproperty
    a_mute_ramp: assert property (p_mute_ramp) else $error("mute ramp stalled");

    property p_gain_step;
        @(posedge sys_clk_in) disable iff (reset_in)
        $changed(gain_r) |-> (gain_r == $past(gain_r) + 8'h01 || gain_r == $past(gain_r) - 8'h01)
            && gain_r <= GAIN_FULL;
    endproperty
    a_gain_step: assert property (p_gain_step) else $error("gain jumped");

    property p_in_count;
        @(posedge sys_clk_in) disable iff (reset_in)
        in_strobe_in |=> in_cnt_r == $past(in_cnt_r) + 1'b1;
    endproperty
    a_in_count: assert property (p_in_count) else $error("input counter missed");

    property p_ratio_hyst;
        @(posedge sys_clk_in) disable iff (reset_in)
        $changed(ratio_r) |-> (ratio_r == RATIO_ONE || $past(rdiff) > RATIO_HYST)
            && ratio_r >= RATIO_MIN && ratio_r <= RATIO_ONE;
    endproperty
    a_ratio_hyst: assert property (p_ratio_hyst) else $error("ratio moved too little");

    property p_load;
        @(posedge sys_clk_in) disable iff (reset_in)
        state_r == ST_LOAD |=> rd_r == $past(phase_r[PH_W-1:FRAC_W]) ##1 state_r == ST_MACR;
    endproperty
    a_load: assert property (p_load) else $error("start pointer not loaded");

    property p_tap_step;
        @(posedge sys_clk_in) disable iff (reset_in)
        state_r == ST_MACR |=> rd_r == $past(rd_r) - 1'b1
            && rom_r == $past(rom_r) + $past(tap_step);
    endproperty
    a_tap_step: assert property (p_tap_step) else $error("tap step wrong");

    property p_end;
        @(posedge sys_clk_in) disable iff (reset_in)
        state_r == ST_DONE |-> $past(state_r) == ST_MACR && $past(rom_sum[ROM_W])
            ##1 out_valid_out;
    endproperty
    a_end: assert property (p_end) else $error("convolution end wrong");

    property p_settle_irq;
        @(posedge sys_clk_in) disable iff (reset_in)
        settle_irq_out |-> $fell(settle_warn_out) && $past(settle_irq_en_in);
    endproperty
    a_settle_irq: assert property (p_settle_irq) else $error("irq without settle");
endmodule : asrc_core

// ### rtl/asrc_pkg.sv
package asrc_pkg;
    // ----------------------------------------
    // Widths and sizes
    // ----------------------------------------
    localparam int SMP_W = 24;
    localparam int RAM_DEPTH = 512;
    localparam int TAPS = 64;
    localparam int TAP_LOG = 6;
    localparam int FRAC_W = 20;
    localparam int ACC_W = 48;
    localparam int OUT_SH = 15;
    // ----------------------------------------
    // Configuration register fields
    // ----------------------------------------
    localparam int DELAY_MSB = 6;
    localparam int MUTE_BIT = 7;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam int OFFSET_MIN = 16;
    // ----------------------------------------
    // Gain, ratio and servo constants
    // ----------------------------------------
    localparam logic [7:0] GAIN_FULL = 8'h40;
    localparam logic [7:0] RATIO_ONE = 8'h40;
    localparam logic [7:0] RATIO_MIN = 8'h09;
    localparam logic [7:0] RATIO_HYST = 8'h02;
    localparam int FAST_P_SH = 2;
    localparam int FAST_I_SH = 6;
    localparam int SLOW_P_SH = 6;
    localparam int SLOW_I_SH = 10;
    localparam logic [6:0] SETTLE_CNT = 7'h40;
    localparam int SETTLED_SMP = 2;
    localparam int UNLOCK_SMP = 8;

    typedef enum logic [2:0]
    {
        ST_IDLE = 3'h0,
        ST_LOAD = 3'h1,
        ST_MACL = 3'h3,
        ST_MACR = 3'h2,
        ST_DONE = 3'h6
    } asrc_state_t;
endpackage : asrc_pkg

// ### test/asrc_partner.sv
// ----------------------------------------
// Audio source and output-rate strobe model
// ----------------------------------------
module asrc_partner
    import asrc_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input var int in_period_in,
    input var int out_period_in,
    input wire logic signed [SMP_W-1:0] amp_in,
    output logic in_strobe_out,
    output logic signed [SMP_W-1:0] in_left_out,
    output logic signed [SMP_W-1:0] in_right_out,
    output logic out_strobe_out
);
    timeunit 1ns;
    timeprecision 1ps;
    int in_cnt_r;
    int out_cnt_r;

    // Left data line carries the inverse between strobes, right line carries amp_in
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            in_cnt_r <= 0;
            in_strobe_out <= 1'b0;
            in_left_out <= '0;
            in_right_out <= '0;
        end
        else if (in_cnt_r >= in_period_in - 1)
        begin
            in_cnt_r <= 0;
            in_strobe_out <= (in_period_in != 0);
            in_left_out <= amp_in;
            in_right_out <= -amp_in;
        end
        else
        begin
            in_cnt_r <= in_cnt_r + 1;
            in_strobe_out <= 1'b0;
            in_left_out <= ~amp_in;
            in_right_out <= amp_in;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            out_cnt_r <= 0;
            out_strobe_out <= 1'b0;
        end
        else if (out_cnt_r >= out_period_in - 1)
        begin
            out_cnt_r <= 0;
            out_strobe_out <= (out_period_in != 0);
        end
        else
        begin
            out_cnt_r <= out_cnt_r + 1;
            out_strobe_out <= 1'b0;
        end
    end
endmodule : asrc_partner

// ### test/tb_asrc_core.sv
module tb_asrc_core
    import asrc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic cfg_wr_in = 1'b0;
    logic [7:0] cfg_data_in = 8'h00;
    logic settle_irq_en_in = 1'b0;
    int in_period = 0;
    int out_period = 0;
    logic signed [SMP_W-1:0] amp = 24'h100000;
    logic in_strobe_in, out_strobe_in, out_valid_out, settle_warn_out, settle_irq_out;
    logic signed [SMP_W-1:0] in_left_in, in_right_in, out_left_out, out_right_out;
    logic [7:0] cfg_data_out, rate_ratio_out;
    int errors = 0;
    int tests_run = 0;

    always #12.5 sys_clk_in = ~sys_clk_in;

    asrc_partner far_end (.clk_in(sys_clk_in), .rst_in(reset_in), .in_period_in(in_period),
        .out_period_in(out_period), .amp_in(amp), .in_strobe_out(in_strobe_in),
        .in_left_out(in_left_in), .in_right_out(in_right_in), .out_strobe_out(out_strobe_in));

    asrc_core dut (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .in_strobe_in(in_strobe_in),
        .in_left_in(in_left_in), .in_right_in(in_right_in), .out_strobe_in(out_strobe_in),
        .cfg_wr_in(cfg_wr_in), .cfg_data_in(cfg_data_in), .settle_irq_en_in(settle_irq_en_in),
        .cfg_data_out(cfg_data_out), .out_left_out(out_left_out), .out_right_out(out_right_out),
        .out_valid_out(out_valid_out), .settle_warn_out(settle_warn_out),
        .settle_irq_out(settle_irq_out), .rate_ratio_out(rate_ratio_out));

    // ----------------------------------------
    // Shared helpers
    // ----------------------------------------
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : close_out

    task automatic chk(input string what, input logic [31:0] lo, input logic [31:0] hi,
        input logic [31:0] got);
        tests_run++;
        if (((got >= lo) && (got <= hi)) !== 1'b1)
        begin
            errors++;
            $display("MISMATCH %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask : chk

    task automatic hang(input string what);
        errors++;
        $display("MISMATCH %s expected event seen timeout", what);
        close_out();
    endtask : hang

    task automatic cycles(input int n);
        repeat (n) @(posedge sys_clk_in);
        #1;
    endtask : cycles

    task automatic cfg_write(input logic [7:0] v);
        @(posedge sys_clk_in);
        cfg_wr_in <= 1'b1;
        cfg_data_in <= v;
        @(posedge sys_clk_in);
        cfg_wr_in <= 1'b0;
        cfg_data_in <= ~v;
        #1;
        chk("cfg_data_out", v, v, cfg_data_out);
    endtask : cfg_write

    task automatic next_out(output int lat);
        int i;
        lat = 0;
        for (i = 0; i < 2000 && out_strobe_in !== 1'b1; i++)
            cycles(1);
        if (i == 2000)
            hang("out_strobe_in");
        for (i = 0; i < 2000 && out_valid_out !== 1'b1; i++)
        begin
            cycles(1);
            lat++;
        end
        if (i == 2000)
            hang("out_valid_out");
        cycles(1);
        chk("out_valid_out pulse", 0, 0, out_valid_out);
    endtask : next_out

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        chk("cfg_data_out", CFG_RESET, CFG_RESET, cfg_data_out);
        chk("settle_warn_out", 1, 1, settle_warn_out);
        chk("rate_ratio_out", RATIO_ONE, RATIO_ONE, rate_ratio_out);
        chk("out_valid_out", 0, 0, out_valid_out);
        chk("settle_irq_out", 0, 0, settle_irq_out);
        $display("Test reset done");
    endtask : t_reset

    task automatic t_cfg();
        cfg_write(8'h85);
        cfg_write(8'h7f);
        cfg_write(8'h00);
        $display("Test config done");
    endtask : t_cfg

    task automatic t_settle();
        int i;
        int irq_n;
        irq_n = 0;
        @(posedge sys_clk_in);
        settle_irq_en_in <= 1'b1;
        in_period <= 160;
        out_period <= 140;
        for (i = 0; i < 30000 && settle_warn_out !== 1'b0; i++)
        begin
            cycles(1);
            if (settle_irq_out === 1'b1)
                irq_n++;
        end
        if (i == 30000)
            hang("settle_warn_out fall");
        for (i = 0; i < 3; i++)
        begin
            cycles(1);
            if (settle_irq_out === 1'b1)
                irq_n++;
        end
        chk("settle_irq_out pulses", 1, 1, irq_n);
        chk("rate_ratio_out", RATIO_ONE, RATIO_ONE, rate_ratio_out);
        $display("Test settle done");
    endtask : t_settle

    task automatic t_conv();
        int lat;
        next_out(lat);
        chk("latency 64 taps", 120, 140, lat);
        chk("out_left_out positive", 1, 1, out_left_out > 0);
        chk("out_right_out negative", 1, 1, out_right_out < 0);
        $display("Test convolution done");
    endtask : t_conv

    task automatic t_mute();
        int lat;
        cfg_write(8'h80);
        cycles(2 * 160);
        next_out(lat);
        chk("out_left_out ramping", 1, 1, out_left_out > 0);
        cycles(145 * 160);
        next_out(lat);
        chk("out_left_out muted", 0, 0, out_left_out);
        chk("out_right_out muted", 0, 0, out_right_out);
        cfg_write(8'h00);
        $display("Test mute done");
    endtask : t_mute

    task automatic t_down();
        int i;
        int lat;
        logic [7:0] held;
        out_period <= 320;
        cycles(2 * 64 * 160);
        for (i = 0; i < 20000 && rate_ratio_out > 8'h22; i++)
            cycles(1);
        if (i == 20000)
            hang("rate_ratio_out update");
        chk("rate_ratio_out", 31, 33, rate_ratio_out);
        held = rate_ratio_out;
        out_period <= 330;
        cycles(2 * 64 * 160);
        chk("rate_ratio_out held", held, held, rate_ratio_out);
        for (i = 0; i < 30000 && settle_warn_out !== 1'b0; i++)
            cycles(1);
        if (i == 30000)
            hang("settle_warn_out fall after rate change");
        next_out(lat);
        chk("latency long filter", 240, 280, lat);
        chk("out_left_out scaled", amp - amp / 4, amp + amp / 8, out_left_out);
        $display("Test downsample done");
    endtask : t_down

    initial
    begin
        repeat (4) @(posedge sys_clk_in);
        reset_in <= 1'b0;
        cycles(1);
        t_reset();
        t_cfg();
        t_settle();
        t_conv();
        t_mute();
        t_down();
        close_out();
    end
endmodule : tb_asrc_core
